// ---- rtl/adcsp_pkg.sv ----
// Package of constants and types for the two-wire converter command port.
package adcsp_pkg;

    // Address byte layout: type prefix in bits 7..3, select in 2..1, direction in 0.
    localparam int unsigned ADDR_TYPE_MSB = 7;
    localparam int unsigned ADDR_TYPE_LSB = 3;
    localparam int unsigned ADDR_SEL_MSB  = 2;
    localparam int unsigned ADDR_SEL_LSB  = 1;
    localparam int unsigned ADDR_DIR_POS  = 0;
    localparam logic        DIR_READ      = 1'b1;

    // Command byte field positions.
    localparam int unsigned CMD_TYPE_POS  = 7;
    localparam int unsigned CMD_CHAN_MSB  = 6;
    localparam int unsigned CMD_CHAN_LSB  = 4;
    localparam int unsigned CMD_PWR_MSB   = 3;
    localparam int unsigned CMD_PWR_LSB   = 2;
    // Bit counter value at which command bit 4 has just been taken (bit 7 is count 1).
    localparam logic [3:0]  CMD_START_CNT = 4'h4;

    // Reset values.
    localparam logic [7:0]  CMD_RESET     = 8'h00;
    localparam logic [7:0]  RESULT_RESET  = 8'h00;

    // High-speed master code, upper five bits 00001, low three bits free.
    localparam logic [4:0]  HS_CODE_TOP   = 5'h01;

    // Power-down encodings.
    localparam logic [1:0]  PWR_BETWEEN   = 2'h0;
    localparam logic [1:0]  PWR_REF_OFF   = 2'h1;
    localparam logic [1:0]  PWR_ADC_OFF   = 2'h2;
    localparam logic [1:0]  PWR_BOTH_ON   = 2'h3;

    // Conversion time on the core clock, in system cycles.
    localparam int unsigned CONV_NS       = 1600;
    localparam int unsigned CLK_NS        = 100;
    localparam logic [7:0]  CONV_CYCLES   = 8'((CONV_NS + CLK_NS - 1) / CLK_NS);

    // Decoded command fields.
    typedef struct packed {
        logic       input_type_select;
        logic [2:0] channel_sel;
        logic [1:0] power_sel;
    } adcsp_cmd_type;

    // Byte-level states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WRITE,
        ST_READ,
        ST_RACK
    } adcsp_state_type;

endpackage : adcsp_pkg

// ---- rtl/adcsp_port.sv ----
// Two-wire slave command port with a modelled converter core.
//
// Notes on behaviour
// - Core clock runs only while converting or addressed; converter also runs while power field bit 0 is set.
// - Bus idle only when both lines high; master starts only then.
// - Data falling while clock high is a start.
// - Data rising while clock high is a stop.
// - Data steady during clock high; changes then are conditions.
// - Bytes of eight bits, then a ninth acknowledge slot.
// - Works at 100kHz and 400kHz bus rates; at 3.4MHz a bus half is shorter than the two 100 ns system cycles it needs.
// - Acknowledge holds data low through the ack clock high.
// - Master does not acknowledge last read byte; device releases data.
// - In writes, device acknowledges address and every following byte.
// - In reads, device sends bytes after the address acknowledge.
// - Repeated start ends one transfer and begins the next.
// - Address recognised in hardware after seven bits and direction.
// - Address is five type bits, two select bits, direction.
// - Select pins sampled at power-up and latched.
// - Direction one is read, zero is write.
// - Acknowledge address only on full type and select match.
// - Command: bit 7 input type, 6..4 channel, 3..2 power.
// - Power field selects reference and converter on or off.
// - Conversion starts at command bit 4; command byte acknowledged.
// - In high-speed, clock held low after read address until done.
// - Stop leaves high-speed mode; repeated start keeps it.
`timescale 1ns/100ps
`default_nettype none

module adcsp_port
    import adcsp_pkg::*;
#(
    // Device type prefix; value is arbitrary.
    parameter logic [4:0] TYPE_PREFIX = 5'h15
) (
    // Clock, reset and enable.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clk_en,
    // Serial bus pins, open drain.
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Select straps.
    input  wire logic       dev_select_pin_hi,
    input  wire logic       dev_select_pin_lo,
    // Converter core interface.
    input  wire logic [7:0] sample_value,
    output adcsp_cmd_type   conversion_command,
    output logic            core_clk_run,
    output logic            converter_on,
    output logic            reference_on,
    output logic            hs_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: three stages, a change counts once stages two and three agree.
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic [1:0] sel_sync [0:2];
    logic       scl_q;
    logic       sda_q;
    logic       scl_prev;
    logic       sda_prev;

    // rate-free sampling; each bus half must span two system cycles, which caps the bus rate.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else if (clk_en) begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            if (scl_sync[1] == scl_sync[2]) scl_q <= scl_sync[2];
            if (sda_sync[1] == sda_sync[2]) sda_q <= sda_sync[2];
            scl_prev <= scl_q;
            sda_prev <= sda_q;
        end
    end

    // Strap synchroniser.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sel_sync[0] <= 2'h0;
            sel_sync[1] <= 2'h0;
            sel_sync[2] <= 2'h0;
        end else if (clk_en) begin
            sel_sync[0] <= {dev_select_pin_hi, dev_select_pin_lo};
            sel_sync[1] <= sel_sync[0];
            sel_sync[2] <= sel_sync[1];
        end
    end

    // Straps are caught once after reset release, when stages two and three agree.
    logic [1:0] dev_sel;
    logic       sel_done;
    logic [1:0] sel_wait;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dev_sel  <= 2'h0;
            sel_done <= 1'b0;
            sel_wait <= 2'h0;
        end else if (clk_en && !sel_done) begin
            if (sel_wait != 2'h3) begin
                sel_wait <= sel_wait + 2'h1;
            end else if (sel_sync[1] == sel_sync[2]) begin
                dev_sel  <= sel_sync[2];
                sel_done <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus condition detection on the filtered lines.
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_rise = clk_en && scl_q && !scl_prev;
    assign scl_fall = clk_en && !scl_q && scl_prev;
    assign start_cond = clk_en && scl_q && scl_prev && sda_prev && !sda_q;
    assign stop_cond = clk_en && scl_q && scl_prev && !sda_prev && sda_q;

    ////////////////////////////////////////////////////////////////////////
    // Byte engine.
    adcsp_state_type state;
    logic [3:0]      bit_cnt;
    logic [7:0]      shift_in;
    logic [7:0]      shift_out;
    logic            addr_match;
    logic            is_read;
    logic            ack_drive;
    logic            tx_bit;
    logic            hs_pending;
    logic            stretch;
    logic            conv_busy;
    logic [7:0]      result;
    logic            start_conv;
    logic [7:0]      addr_byte;

    assign addr_byte = {shift_in[6:0], sda_q};
    // match decode
    // The decision is taken on the eighth fall, when the whole byte already sits in the shifter.
    assign addr_match = (shift_in[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == TYPE_PREFIX)
                        && (shift_in[ADDR_SEL_MSB:ADDR_SEL_LSB] == dev_sel);
    // command bit 4, or a matched high-speed read address, starts a conversion.
    assign start_conv = ((state == ST_WRITE) && scl_rise && (bit_cnt == CMD_START_CNT - 4'h1))
                        || ((state == ST_ADDR) && hs_mode && scl_fall && (bit_cnt == 4'h8) && addr_match
                            && (shift_in[ADDR_DIR_POS] == DIR_READ));

    // Main sequence: sample on clock rise, advance on clock fall, except ST_RACK, which advances on the rise.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state     <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shift_in  <= 8'h00;
            shift_out <= RESULT_RESET;
            is_read   <= 1'b0;
            ack_drive <= 1'b0;
            tx_bit    <= 1'b1;
        end else if (start_cond) begin
            state     <= ST_ADDR;
            bit_cnt   <= 4'h0;
            ack_drive <= 1'b0;
            tx_bit    <= 1'b1;
        end else if (stop_cond) begin
            state     <= ST_IDLE;
            ack_drive <= 1'b0;
            tx_bit    <= 1'b1;
        end else if (clk_en) begin
            unique case (state)
                ST_IDLE: begin
                    bit_cnt <= 4'h0;
                end
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_in <= addr_byte;
                        bit_cnt  <= bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == 4'h8) begin
                        bit_cnt <= 4'h0;
                        if (state == ST_WRITE) begin
                            ack_drive <= 1'b1;
                            state     <= ST_ACK;
                        end else if (addr_match) begin
                            ack_drive <= 1'b1;
                            is_read   <= (shift_in[ADDR_DIR_POS] == DIR_READ);
                            state     <= ST_ACK;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !stretch) begin
                        ack_drive <= 1'b0;
                        if (is_read) begin
                            // first bit set while clock low
                            shift_out <= {result[6:0], 1'b0};
                            tx_bit    <= result[7];
                            bit_cnt   <= 4'h1;
                            state     <= ST_READ;
                        end else begin
                            state <= ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    // shift out MSB first on clock fall
                    if (scl_fall) begin
                        if (bit_cnt == 4'h8) begin
                            tx_bit <= 1'b1;
                            state  <= ST_RACK;
                        end else begin
                            tx_bit    <= shift_out[7];
                            shift_out <= {shift_out[6:0], 1'b0};
                            bit_cnt   <= bit_cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        state <= sda_q ? ST_IDLE : ST_ACK;
                    end
                end
            endcase
        end
    end

    // Master code and high-speed mode tracking.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hs_pending <= 1'b0;
            hs_mode    <= 1'b0;
        end else if (stop_cond) begin
            hs_pending <= 1'b0;
            hs_mode    <= 1'b0;
        end else if (start_cond) begin
            // restart after master code enters high speed
            if (hs_pending) hs_mode <= 1'b1;
            hs_pending <= 1'b0;
        end else if (clk_en && state == ST_ADDR && scl_fall && bit_cnt == 4'h8) begin
            hs_pending <= (shift_in[7:3] == HS_CODE_TOP);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command register, written from the shifter on the eighth clock fall of a command byte.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conversion_command <= adcsp_cmd_type'(6'(CMD_RESET >> CMD_PWR_LSB));
        end else if (clk_en && state == ST_WRITE && scl_fall && bit_cnt == 4'h8) begin
            conversion_command.input_type_select <= shift_in[CMD_TYPE_POS];
            conversion_command.channel_sel       <= shift_in[CMD_CHAN_MSB:CMD_CHAN_LSB];
            conversion_command.power_sel         <= shift_in[CMD_PWR_MSB:CMD_PWR_LSB];
        end
    end

    // Conversion model: counts the conversion time, then captures the sample.
    logic [7:0] conv_cnt;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conv_busy <= 1'b0;
            conv_cnt  <= 8'h00;
            result    <= RESULT_RESET;
        end else if (clk_en) begin
            if (start_conv) begin
                conv_busy <= 1'b1;
                conv_cnt  <= CONV_CYCLES;
            end else if (conv_busy) begin
                if (conv_cnt == 8'h01) begin
                    conv_busy <= 1'b0;
                    result    <= sample_value;
                end
                conv_cnt <= conv_cnt - 8'h01;
            end
        end
    end

    // stretch after read address while converting
    assign stretch = hs_mode && is_read && (state == ST_ACK) && conv_busy;

    // core clock only when busy or addressed
    assign core_clk_run = conv_busy || (state != ST_IDLE);
    assign converter_on = conv_busy || conversion_command.power_sel[0];
    assign reference_on = conversion_command.power_sel[1];

    // Open-drain drivers: enable only when pulling low.
    assign sda_out = 1'b0;
    assign sda_oe  = ack_drive || (state == ST_READ && !tx_bit);
    assign scl_out = 1'b0;
    assign scl_oe  = stretch && !scl_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    a_ack_low_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_ACK && !is_read) |-> sda_oe)
        else $error("ack not driven");
    a_stop_ends_hs: assert property (@(posedge clk_sys) disable iff (rst)
        stop_cond |=> !hs_mode)
        else $error("high speed kept after stop");
    a_start_to_addr: assert property (@(posedge clk_sys) disable iff (rst)
        start_cond |=> (state == ST_ADDR && bit_cnt == 4'h0))
        else $error("start not taken");
    a_stop_to_idle: assert property (@(posedge clk_sys) disable iff (rst)
        stop_cond |=> (state == ST_IDLE && !sda_oe))
        else $error("stop not taken");
    a_conv_starts: assert property (@(posedge clk_sys) disable iff (rst)
        start_conv && clk_en |=> conv_busy && conv_cnt == CONV_CYCLES)
        else $error("conversion not started");
    a_core_off_idle: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_IDLE && !conv_busy) |-> !core_clk_run)
        else $error("core clock running when idle");
    a_nomatch_release: assert property (@(posedge clk_sys) disable iff (rst)
        (clk_en && state == ST_ADDR && scl_fall && bit_cnt == 4'h8 && !addr_match && !start_cond && !stop_cond)
        |=> !sda_oe)
        else $error("acknowledged foreign address");
    a_nack_release: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_RACK) |-> !sda_oe)
        else $error("data held after byte");
    a_stretch_only_hs: assert property (@(posedge clk_sys) disable iff (rst)
        scl_oe |-> hs_mode && conv_busy)
        else $error("clock held outside high speed");
    a_data_low_edge: assert property (@(posedge clk_sys) disable iff (rst)
        (state == ST_READ && scl_q && $past(scl_q) && !start_cond) |=> $stable(tx_bit) || stop_cond)
        else $error("data changed with clock high");

    c_write_ack: cover property (@(posedge clk_sys) state == ST_ACK && !is_read);
    c_read_byte: cover property (@(posedge clk_sys) state == ST_RACK);
    c_hs_entry: cover property (@(posedge clk_sys) $rose(hs_mode));
    c_stretch: cover property (@(posedge clk_sys) scl_oe);

endmodule : adcsp_port

`default_nettype wire

// ---- tb/adcsp_master.sv ----
// Behavioural two-wire bus master that drives the converter command port.
`timescale 1ns/100ps
`default_nettype none

module adcsp_master (
    // Bench clock.
    input  wire logic clk_sys,
    // Resolved bus lines.
    input  wire logic scl_i,
    input  wire logic sda_i,
    // Open-drain drive levels, 1 means released to the pull-up.
    output var logic  scl_o,
    output var logic  sda_o
);
    // Phase lengths in system cycles: six low and two high make the 800 ns bus period.
    // Data changes late in the low phase, after the slave has seen the fall, so it never races the slave.
    localparam int LOW_PRE  = 5;
    localparam int LOW_POST = 1;
    localparam int HIGH     = 2;
    // Bus-free time after a stop, long enough for the slave to act on the stop.
    localparam int IDLE_GAP = 12;
    int stretch;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waits a number of system clock edges.
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wait_cyc

    // one pulse, data set while low.
    task automatic pulse(input logic b, output logic r);
        wait_cyc(LOW_PRE);
        sda_o <= b;
        wait_cyc(LOW_POST);
        scl_o <= 1'b1;
        stretch = 0;
        @(posedge clk_sys);
        // A slave holding the clock low delays the high phase, with a bound.
        while (scl_i !== 1'b1 && stretch < 400) begin
            @(posedge clk_sys);
            stretch++;
        end
        wait_cyc(HIGH - 1);
        r = sda_i;
        scl_o <= 1'b0;
    endtask : pulse

    // eight bits then the acknowledge slot.
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            pulse(d[i], q[i]);
        end
        pulse(ack_in, ack_out);
    endtask : xfer

    // start from idle, or repeated start from a low clock.
    task automatic start();
        @(posedge clk_sys);
        if (scl_o === 1'b0) begin
            wait_cyc(LOW_PRE);
            sda_o <= 1'b1;
            wait_cyc(LOW_POST);
            scl_o <= 1'b1;
            wait_cyc(HIGH);
        end
        sda_o <= 1'b0;
        wait_cyc(HIGH);
        scl_o <= 1'b0;
    endtask : start

    // stop after any number of bytes, then an idle gap.
    task automatic stop();
        wait_cyc(LOW_PRE);
        sda_o <= 1'b0;
        wait_cyc(LOW_POST);
        scl_o <= 1'b1;
        wait_cyc(HIGH);
        sda_o <= 1'b1;
        wait_cyc(IDLE_GAP);
    endtask : stop

endmodule : adcsp_master
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the converter command port.
`timescale 1ns/100ps
`default_nettype none

module tb
    import adcsp_pkg::*;
;
    // Device type prefix for the bench; value is arbitrary.
    localparam logic [4:0] PREFIX = 5'h0d;
    localparam logic [1:0] STRAP  = 2'h2;
    logic          clk_sys, rst, scl_m, sda_m, scl_out, scl_oe, sda_out, sda_oe, scl_w, sda_w;
    logic          sel_hi, sel_lo, core_clk_run, converter_on, reference_on, hs_mode, ack;
    logic          en;
    logic          stretched = 1'b0;
    logic [7:0]    sample_value, rd;
    adcsp_cmd_type cmd;
    int            bad_count = 0;
    int            n_checks  = 0;
    int            cycles    = 0;

    // Open-drain wires with pull-ups.
    assign scl_w = scl_m & (scl_oe ? scl_out : 1'b1);
    assign sda_w = sda_m & (sda_oe ? sda_out : 1'b1);

    adcsp_port #(.TYPE_PREFIX(PREFIX)) dut (
        .clk_sys(clk_sys), .rst(rst), .clk_en(en),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
        .dev_select_pin_hi(sel_hi), .dev_select_pin_lo(sel_lo),
        .sample_value(sample_value), .conversion_command(cmd), .core_clk_run(core_clk_run),
        .converter_on(converter_on), .reference_on(reference_on), .hs_mode(hs_mode)
    );

    adcsp_master m (.clk_sys(clk_sys), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));

    // System clock, 100 ns period.
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // Remembers that the port has held the bus clock low at least once.
    always @(posedge clk_sys) begin
        if (scl_oe) stretched <= 1'b1;
    end

    // Cuts a hang short; the whole run needs well under this.
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compares a byte result.
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    // Compares a single flag.
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    // Writes one byte and checks the slave's answer in the ninth slot.
    task automatic send(input logic [7:0] d, input logic exp_ack);
        m.xfer(d, 1'b1, rd, ack);
        chk_bit(ack, exp_ack);
    endtask : send

    ////////////////////////////////////////////////////////////////////////////////
    // Quiet state after reset; a start seen while the enable is low must leave the port frozen.
    task automatic t_reset();
        en <= 1'b0;
        m.start();
        repeat (8) @(posedge clk_sys);
        chk_bit(core_clk_run, 1'b0);
        m.stop();
        en <= 1'b1;
        chk_bit(sda_oe | scl_oe, 1'b0);
        chk_byte({2'h0, cmd}, 8'h00);
        chk_bit(core_clk_run, 1'b0);
        chk_bit(hs_mode, 1'b0);
    endtask : t_reset

    // Several commands in one write, every power setting, last one powers down.
    task automatic t_write();
        logic [7:0] c;
        m.start();
        send({PREFIX, STRAP, 1'b0}, 1'b0);
        for (int p = 3; p >= 0; p--) begin
            c = {~p[0], 3'(p + 4), 2'(p), 2'h1};
            send(c, 1'b0);
            chk_byte({2'h0, cmd}, {2'h0, c[7:2]});
            chk_bit(reference_on, c[3]);
            chk_bit(converter_on, c[2]);
            chk_bit(core_clk_run, 1'b1);
        end
        m.stop();
        repeat (20) @(posedge clk_sys);
        chk_bit(core_clk_run, 1'b0);
    endtask : t_write

    // Addresses with a wrong select or prefix are left unanswered.
    task automatic t_refuse();
        logic [7:0] a [3];
        a = '{{PREFIX, ~STRAP, 1'b0}, {PREFIX ^ 5'h10, STRAP, 1'b0}, {PREFIX, STRAP ^ 2'h1, 1'b1}};
        for (int i = 0; i < 3; i++) begin
            m.start();
            send(a[i], 1'b1);
            m.stop();
        end
    endtask : t_refuse

    // Command, repeated start, two result bytes, then release after the last.
    task automatic t_read();
        sample_value <= 8'h96;
        m.start();
        send({PREFIX, STRAP, 1'b0}, 1'b0);
        send(8'h84, 1'b0);
        m.start();
        send({PREFIX, STRAP, 1'b1}, 1'b0);
        m.xfer(8'hff, 1'b0, rd, ack);
        chk_byte(rd, 8'h96);
        m.xfer(8'hff, 1'b1, rd, ack);
        chk_byte(rd, 8'h96);
        repeat (6) @(posedge clk_sys);
        chk_bit(sda_w, 1'b1);
        m.stop();
    endtask : t_read

    // Master code, high-speed traffic across a repeated start, stop returns to normal.
    task automatic t_hs();
        chk_bit(stretched, 1'b0);
        m.start();
        send(8'h0b, 1'b1);
        m.start();
        send({PREFIX, STRAP, 1'b0}, 1'b0);
        chk_bit(hs_mode, 1'b1);
        send(8'h8c, 1'b0);
        sample_value <= 8'h5a;
        m.start();
        send({PREFIX, STRAP, 1'b1}, 1'b0);
        chk_bit(stretched, 1'b1);
        chk_bit(hs_mode, 1'b1);
        m.xfer(8'hff, 1'b1, rd, ack);
        chk_byte(rd, 8'h5a);
        m.stop();
        chk_bit(hs_mode, 1'b0);
    endtask : t_hs

    // Stop in mid-byte, then a clean transfer still works.
    task automatic t_abort();
        m.start();
        send({PREFIX, STRAP, 1'b0}, 1'b0);
        for (int i = 0; i < 3; i++) begin
            m.pulse(1'b1, ack);
        end
        m.stop();
        m.start();
        send({PREFIX, STRAP, 1'b0}, 1'b0);
        send(8'h44, 1'b0);
        m.stop();
        chk_byte({2'h0, cmd}, 8'h11);
    endtask : t_abort

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // Main sequence: straps stable from time zero, reset for ten cycles, idle bus before the first start.
    initial begin
        rst          = 1'b1;
        sample_value = 8'h00;
        en           = 1'b1;
        sel_hi       = STRAP[1];
        sel_lo       = STRAP[0];
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (20) @(posedge clk_sys);
        t_reset();
        t_write();
        t_refuse();
        t_read();
        t_hs();
        t_abort();
        results();
    end

endmodule : tb
`default_nettype wire
